// ===== offset_cancel_filter_sequencer.sv
// offset cancellation filter, phase sequencer, rate limiter, fifo and interpolator
// How it works
// - phase 0: 256us updates, 163.8Hz, 4.096ms
// - phase 1: 256us updates, 40.96Hz, 4.096ms
// - phase 2: 256us updates, 10.24Hz, 16.388ms
// - phase 3: 256us updates, 2.560Hz, 65.53ms
// - phase 4: 256us updates, 0.64Hz, 262.19ms
// - phase 5: 256us updates, 0.16Hz, 1049ms
// - final variant a: 256us updates, 0.04Hz
// - final variant b: 1024us updates, 0.005Hz
// - variant a only: applied offset moves every 2s
// - 10-bit output: limiter step is 0.5 LSB
// - 16-bit output: limiter step is 32 LSB
// - sinc-to-output latency at most 128us
// - interpolated points every 1us at fastest rate
`timescale 1ns/10ps

module sample_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // write side
   input  wire logic         wr_valid,
   input  wire logic [W-1:0] wr_data,
   output logic              wr_ready,
   // read side
   output logic              rd_valid,
   output logic [W-1:0]      rd_data,
   input  wire logic         rd_ready,
   // fill level
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wptr;
   logic [AW-1:0] rptr;
   wire           wr_fire = wr_valid && wr_ready;
   wire           rd_fire = rd_valid && rd_ready;

   assign wr_ready = level != (AW+1)'(DEPTH);
   assign rd_valid = level != '0;
   assign rd_data  = mem[rptr];

   always_ff @(posedge clk) begin
      if (wr_fire) begin
         mem[wptr] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr  <= '0;
         rptr  <= '0;
         level <= '0;
      end else begin
         wptr  <= wr_fire ? wptr + 1'b1 : wptr;
         rptr  <= rd_fire ? rptr + 1'b1 : rptr;
         level <= level + (AW+1)'(wr_fire) - (AW+1)'(rd_fire);
      end
   end
endmodule

module offset_cancel_filter_sequencer
   import offset_cancel_pkg::*;
#(
   parameter int DW       = offset_cancel_pkg::SAMPLE_WIDTH,
   parameter int DEPTH    = offset_cancel_pkg::FIFO_DEPTH_WORDS,
   parameter int UPD_CYC  = offset_cancel_pkg::UPDATE_CYCLES,
   parameter int SLOW_CYC = offset_cancel_pkg::SLOW_UPDATE_CYCLES,
   parameter int LIM_CYC  = offset_cancel_pkg::LIMITER_CYCLES
) (
   // clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   // static configuration
   input  wire offset_cancel_pkg::chain_cfg_t cfg,
   // samples from the decimation filter
   input  wire offset_cancel_pkg::sample_t   in_sample,
   output logic                              in_ready,
   // samples to the output formatter
   output offset_cancel_pkg::sample_t        out_sample,
   input  wire logic                         out_ready,
   // status
   output offset_cancel_pkg::phase_t         phase,
   output logic signed [DW-1:0]              applied_offset
);
   import offset_cancel_pkg::*;

   localparam int FW        = DW + EST_FRAC_BITS;
   localparam int AW        = $clog2(DEPTH);
   localparam int NARROW_SZ = (1 << (DW - NARROW_OUT_BITS)) * LIMIT_STEP_NARROW_HALF / 2;
   localparam int LAT_BOUND = 401;

   function automatic logic [3:0] shift_of(phase_t p, logic slow);
      int i;
      i = phase_index(p);
      if (i == 6 && slow) begin
         i = 7;
      end
      return 4'(PHASE_SHIFT[i]);
   endfunction

   function automatic logic [15:0] step_cycles(logic [1:0] sel);
      return 16'(INTERP_STEP_US[sel] * 1000 / CLK_PERIOD_NS);
   endfunction

   // update tick and phase sequencing
   logic [31:0] tick_cnt;
   logic [15:0] dwell_cnt;
   wire         slow_mode  = (phase == PH_FINAL) && cfg.final_slow;
   wire  [31:0] tick_len   = slow_mode ? 32'(SLOW_CYC) : 32'(UPD_CYC);
   wire         tick       = tick_cnt >= tick_len - 32'd1;
   wire  [15:0] dwell_len  = dwell_ticks(phase);
   wire         dwell_done = tick && (phase != PH_FINAL) && (dwell_cnt == dwell_len - 16'd1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt  <= '0;
         dwell_cnt <= '0;
         phase     <= PH0;
      end else begin
         tick_cnt  <= tick ? '0 : tick_cnt + 32'd1;
         dwell_cnt <= dwell_done ? '0 : (tick ? dwell_cnt + 16'd1 : dwell_cnt);
         phase     <= dwell_done ? next_phase(phase) : phase;
      end
   end

   // one-pole offset estimate
   logic signed [DW-1:0] last_sample;
   logic signed [FW-1:0] est;
   wire         [3:0]    shift   = shift_of(phase, cfg.final_slow);
   wire  signed [FW-1:0] x_ext   = {last_sample, {EST_FRAC_BITS{1'b0}}};
   wire  signed [FW:0]   err     = {x_ext[FW-1], x_ext} - {est[FW-1], est};
   wire  signed [FW:0]   err_sh  = err >>> shift;
   wire  signed [FW-1:0] next_est = FW'(est + err_sh);
   wire  signed [DW-1:0] est_int = est[FW-1:EST_FRAC_BITS];
   wire                  in_fire = in_sample.valid && in_ready;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_sample <= '0;
         est         <= FW'(ESTIMATE_RESET);
      end else begin
         last_sample <= in_fire ? in_sample.data : last_sample;
         est         <= tick ? next_est : est;
      end
   end

   // rate limiter
   logic [31:0]          lim_cnt;
   logic signed [DW-1:0] limited;
   wire                  lim_on   = (phase == PH_FINAL) && !cfg.final_slow;
   wire                  lim_tick = lim_on && (lim_cnt == 32'(LIM_CYC) - 32'd1);
   wire  signed [DW:0]   step     = cfg.narrow_out ? (DW+1)'(NARROW_SZ)
                                                   : (DW+1)'(LIMIT_STEP_WIDE_LSB);
   wire  signed [DW:0]   gap      = {est_int[DW-1], est_int} - {limited[DW-1], limited};
   wire  signed [DW-1:0] lim_up   = DW'({limited[DW-1], limited} + step);
   wire  signed [DW-1:0] lim_dn   = DW'({limited[DW-1], limited} - step);
   wire  signed [DW-1:0] next_limited = !lim_on ? est_int
                                      : !lim_tick ? limited
                                      : (gap >= step) ? lim_up
                                      : (gap <= -step) ? lim_dn
                                      : limited;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lim_cnt        <= '0;
         limited        <= '0;
         applied_offset <= '0;
      end else begin
         lim_cnt        <= (!lim_on || lim_tick) ? '0 : lim_cnt + 32'd1;
         limited        <= next_limited;
         applied_offset <= lim_on ? limited : est_int;
      end
   end

   // offset subtraction with saturation
   sample_t              sub;
   wire  signed [DW:0]   diff  = {in_sample.data[DW-1], in_sample.data}
                               - {applied_offset[DW-1], applied_offset};
   wire                  ovf   = diff[DW] != diff[DW-1];
   wire  signed [DW-1:0] corrected = ovf ? {diff[DW], {(DW-1){~diff[DW]}}} : diff[DW-1:0];
   wire         [AW:0]   level;
   wire                  fifo_wr_ready;
   wire                  fifo_rd_valid;
   wire         [DW-1:0] fifo_rd_data;
   wire                  pop;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sub      <= '0;
         in_ready <= 1'b0;
      end else begin
         sub.valid <= in_fire;
         sub.data  <= in_fire ? corrected : sub.data;
         in_ready  <= level <= (AW+1)'(DEPTH - 3);
      end
   end

   sample_fifo #(
      .W     (DW),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rst_n    (rst_n),
      .wr_valid (sub.valid),
      .wr_data  (sub.data),
      .wr_ready (fifo_wr_ready),
      .rd_valid (fifo_rd_valid),
      .rd_data  (fifo_rd_data),
      .rd_ready (pop),
      .level    (level)
   );

   // 1 to 16 interpolator
   logic signed [DW-1:0] prev;
   logic signed [DW-1:0] cur;
   logic [4:0]           idx;
   logic [15:0]          step_cnt;
   wire  [15:0]          step_len  = step_cycles(cfg.chain_period_sel);
   wire                  step_due  = step_cnt >= step_len - 16'd1;
   wire                  idle      = idx == 5'(INTERP_POINTS);
   wire                  emit      = !idle && step_due && (!out_sample.valid || out_ready);
   wire  [4:0]           pos       = idx + 5'd1;
   wire  signed [DW:0]   span      = {cur[DW-1], cur} - {prev[DW-1], prev};
   wire  signed [DW+6:0] prod      = span * $signed({1'b0, pos});
   wire  signed [DW+6:0] frac      = prod >>> 4;
   wire  signed [DW-1:0] point     = DW'(frac + (DW+7)'(prev));
   assign pop = idle && fifo_rd_valid;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev       <= '0;
         cur        <= '0;
         idx        <= 5'(INTERP_POINTS);
         step_cnt   <= '0;
         out_sample <= '0;
      end else begin
         prev     <= pop ? cur : prev;
         cur      <= pop ? fifo_rd_data : cur;
         idx      <= pop ? 5'd0 : (emit ? pos : idx);
         step_cnt <= emit ? '0 : (step_due ? step_cnt : step_cnt + 16'd1);
         if (emit) begin
            out_sample.valid <= 1'b1;
            out_sample.data  <= point;
         end else if (out_ready) begin
            out_sample.valid <= 1'b0;
         end
      end
   end

   // checking helpers
   logic [31:0] tick_gap;
   logic [15:0] emit_gap;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_gap <= '0;
         emit_gap <= 16'hffff;
      end else begin
         tick_gap <= tick ? '0 : tick_gap + 32'd1;
         emit_gap <= emit ? '0 : (emit_gap == 16'hffff ? emit_gap : emit_gap + 16'd1);
      end
   end

   property p_update_fast;
      @(posedge clk) disable iff (!rst_n)
      tick && !slow_mode |-> tick_gap == 32'(UPD_CYC) - 32'd1;
   endproperty
   a_update_fast: assert property (p_update_fast)
      else $error("fast update period wrong");

   property p_update_slow;
      @(posedge clk) disable iff (!rst_n)
      tick && slow_mode |-> tick_gap == 32'(SLOW_CYC) - 32'd1;
   endproperty
   a_update_slow: assert property (p_update_slow)
      else $error("slow update period wrong");

   property p_phase_order;
      @(posedge clk) disable iff (!rst_n)
      (phase != $past(phase)) |-> phase == next_phase($past(phase)) && $past(dwell_done);
   endproperty
   a_phase_order: assert property (p_phase_order)
      else $error("phase changed out of order");

   property p_dwell_length;
      @(posedge clk) disable iff (!rst_n)
      $changed(phase) |-> $past(dwell_cnt) == $past(dwell_len) - 16'd1;
   endproperty
   a_dwell_length: assert property (p_dwell_length)
      else $error("phase dwell length wrong");

   property p_final_sticks;
      @(posedge clk) disable iff (!rst_n)
      phase == PH_FINAL |=> phase == PH_FINAL [*4];
   endproperty
   a_final_sticks: assert property (p_final_sticks)
      else $error("left the final phase");

   property p_limit_timing;
      @(posedge clk) disable iff (!rst_n)
      lim_on && $past(lim_on) && $changed(limited) |-> $past(lim_tick);
   endproperty
   a_limit_timing: assert property (p_limit_timing)
      else $error("limited offset moved between intervals");

   property p_limit_step;
      @(posedge clk) disable iff (!rst_n)
      lim_on && $past(lim_on) && $changed(limited) |->
         ((DW+1)'(limited) - (DW+1)'($past(limited)) == step)
         || ((DW+1)'($past(limited)) - (DW+1)'(limited) == step);
   endproperty
   a_limit_step: assert property (p_limit_step)
      else $error("limiter step size wrong");

   property p_subtract;
      @(posedge clk) disable iff (!rst_n)
      in_fire && !ovf |=> DW'(sub.data + $past(applied_offset)) == $past(in_sample.data);
   endproperty
   a_subtract: assert property (p_subtract)
      else $error("offset not subtracted");

   property p_no_overflow;
      @(posedge clk) disable iff (!rst_n)
      sub.valid |-> fifo_wr_ready;
   endproperty
   a_no_overflow: assert property (p_no_overflow)
      else $error("sample lost at fifo input");

   property p_chain_latency;
      @(posedge clk) disable iff (!rst_n)
      pop |-> ##[1:LAT_BOUND] out_sample.valid;
   endproperty
   a_chain_latency: assert property (p_chain_latency)
      else $error("output not produced in time");

   property p_interp_step;
      @(posedge clk) disable iff (!rst_n)
      emit && (emit_gap != 16'hffff) |-> emit_gap >= step_len - 16'd1;
   endproperty
   a_interp_step: assert property (p_interp_step)
      else $error("interpolated points too close");

endmodule

// ===== offset_cancel_pkg.sv
// shared constants, types and helpers for the offset cancellation chain
package offset_cancel_pkg;

   localparam int CLK_PERIOD_NS          = 10;
   localparam int SAMPLE_WIDTH           = 16;
   localparam int EST_FRAC_BITS          = 16;
   localparam int FIFO_DEPTH_WORDS       = 16;

   // estimate update periods
   localparam int UPDATE_PERIOD_US       = 256;
   localparam int SLOW_UPDATE_PERIOD_US  = 1024;
   localparam int UPDATE_CYCLES          = UPDATE_PERIOD_US * 1000 / CLK_PERIOD_NS;
   localparam int SLOW_UPDATE_CYCLES     = SLOW_UPDATE_PERIOD_US * 1000 / CLK_PERIOD_NS;

   // dwell time of phases 0..5 in us, then the final phase
   localparam int PHASE_DWELL_US [6]     = '{4096, 4096, 16388, 65530, 262190, 1049000};
   // cutoff in mHz and matching one-pole shift, phases 0..5, final a, final b
   localparam int PHASE_CUTOFF_MHZ [8]   = '{163800, 40960, 10240, 2560, 640, 160, 40, 5};
   localparam int PHASE_SHIFT [8]        = '{2, 4, 6, 8, 10, 12, 14, 15};

   // rate limiter
   localparam int LIMITER_INTERVAL_MS    = 2000;
   localparam int LIMITER_CYCLES         = LIMITER_INTERVAL_MS * (1000000 / CLK_PERIOD_NS);
   localparam int LIMIT_STEP_WIDE_LSB    = 32;
   localparam int NARROW_OUT_BITS        = 10;
   localparam int LIMIT_STEP_NARROW_HALF = 1;

   // latency bound and interpolator
   localparam int CHAIN_LATENCY_MAX_US   = 128;
   localparam int CHAIN_LATENCY_CYCLES   = CHAIN_LATENCY_MAX_US * 1000 / CLK_PERIOD_NS;
   localparam int INTERP_POINTS          = 16;
   localparam int INTERP_STEP_US [4]     = '{1, 1, 2, 4};
   localparam int ESTIMATE_RESET         = 0;

   typedef enum logic [6:0] {
      PH0      = 7'h01,
      PH1      = 7'h02,
      PH2      = 7'h04,
      PH3      = 7'h08,
      PH4      = 7'h10,
      PH5      = 7'h20,
      PH_FINAL = 7'h40
   } phase_t;

   typedef struct packed {
      logic       final_slow;
      logic       narrow_out;
      logic [1:0] chain_period_sel;
   } chain_cfg_t;

   typedef struct packed {
      logic                           valid;
      logic signed [SAMPLE_WIDTH-1:0] data;
   } sample_t;

   function automatic int phase_index(phase_t p);
      case (p)
         PH0:     return 0;
         PH1:     return 1;
         PH2:     return 2;
         PH3:     return 3;
         PH4:     return 4;
         PH5:     return 5;
         default: return 6;
      endcase
   endfunction

   function automatic phase_t next_phase(phase_t p);
      case (p)
         PH0:     return PH1;
         PH1:     return PH2;
         PH2:     return PH3;
         PH3:     return PH4;
         PH4:     return PH5;
         default: return PH_FINAL;
      endcase
   endfunction

   // dwell in update ticks, nearest whole tick
   function automatic logic [15:0] dwell_ticks(phase_t p);
      int i;
      i = phase_index(p);
      if (i > 5) begin
         return 16'hffff;
      end
      return 16'((PHASE_DWELL_US[i] + UPDATE_PERIOD_US / 2) / UPDATE_PERIOD_US);
   endfunction

endpackage

// ===== formatter_model.sv
// output formatter model: takes interpolated points, stalls on command
`timescale 1ns/10ps
module formatter_model
   import offset_cancel_pkg::*;
(
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   // point stream from the block
   input  wire offset_cancel_pkg::sample_t out_sample,
   output logic                            out_ready,
   // bench control
   input  wire logic                       stall
);
   import offset_cancel_pkg::*;

   int                 cyc = 0;
   logic signed [15:0] pts[$];
   int                 stamps[$];

   // ready withheld while the bench asks for a stall
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_ready <= 1'b0;
      end else begin
         out_ready <= !stall;
      end
   end

   // log every point taken, with its cycle
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rst_n && out_sample.valid && out_ready) begin
         pts.push_back(out_sample.data);
         stamps.push_back(cyc);
      end
   end
endmodule

// ===== testbench.sv
// self-checking bench for the offset cancellation chain
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin failures++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
   import offset_cancel_pkg::*;

   localparam int UPD  = 8;
   localparam int SLOW = 16;
   localparam int LIM  = 64;
   localparam int TICKS [6] = '{16, 16, 64, 256, 1024, 4098};
   localparam int DEPTH_OK_LO = FIFO_DEPTH_WORDS - 3;
   // half an lsb of the narrow output, in lsbs of the wide word
   localparam int STEP_NARROW = (1 << (16 - NARROW_OUT_BITS)) / 2;

   logic               clk;
   logic               rst_n;
   chain_cfg_t         cfg;
   sample_t            in_sample;
   logic               in_ready;
   sample_t            out_sample;
   logic               out_ready;
   phase_t             phase;
   logic signed [15:0] applied_offset;
   logic               stall;
   int                 failures = 0;
   int                 checks_done = 0;
   int                 take_cyc;
   logic signed [15:0] off0;
   logic signed [15:0] off1;
   int                 s;

   offset_cancel_filter_sequencer #(.UPD_CYC(UPD), .SLOW_CYC(SLOW), .LIM_CYC(LIM)) u_dut (
      .clk            (clk),
      .rst_n          (rst_n),
      .cfg            (cfg),
      .in_sample      (in_sample),
      .in_ready       (in_ready),
      .out_sample     (out_sample),
      .out_ready      (out_ready),
      .phase          (phase),
      .applied_offset (applied_offset)
   );

   formatter_model u_fmt (
      .clk        (clk),
      .rst_n      (rst_n),
      .out_sample (out_sample),
      .out_ready  (out_ready),
      .stall      (stall)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic summarize();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic bail();
      failures++;
      $display("wait ran out at t=%0t", $time);
      summarize();
   endtask

   task automatic do_reset(input chain_cfg_t c);
      rst_n <= 1'b0;
      cfg <= c;
      in_sample <= '0;
      stall <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      u_fmt.pts.delete();
      u_fmt.stamps.delete();
      @(posedge clk);
   endtask

   // one sample, held until taken; offsets seen around the take
   task automatic send(input logic signed [15:0] d);
      int n;
      @(posedge clk);
      in_sample <= '{valid: 1'b1, data: d};
      for (n = 0; n < 5000; n++) begin
         @(posedge clk);
         if (in_ready === 1'b1) break;
      end
      if (n == 5000) bail();
      take_cyc = u_fmt.cyc;
      off0 = applied_offset;
      in_sample.valid <= 1'b0;
      @(posedge clk);
      off1 = applied_offset;
   endtask

   task automatic wait_points(input int n, input int bound);
      int i;
      for (i = 0; i < bound; i++) begin
         @(posedge clk);
         if (u_fmt.pts.size() >= n) break;
      end
      if (i == bound) bail();
   endtask

   task automatic t_interp(input logic [1:0] sel);
      int   step;
      int   k;
      logic ok;
      step = (sel == 2'h3) ? 400 : (sel == 2'h2) ? 200 : 100;
      do_reset('{final_slow: 1'b0, narrow_out: 1'b0, chain_period_sel: sel});
      send(16'sh1000);
      wait_points(16, 20 * step + 50);
      repeat (2 * step) @(posedge clk);
      `CHK(u_fmt.pts.size(), 16)
      for (k = 1; k < 16; k++) `CHK(u_fmt.stamps[k] - u_fmt.stamps[k-1], step)
      `CHK(u_fmt.stamps[0] - take_cyc <= CHAIN_LATENCY_CYCLES, 1'b1)
      ok = (u_fmt.pts[15] === 16'(16'sh1000 - off0)) || (u_fmt.pts[15] === 16'(16'sh1000 - off1));
      `CHK(ok, 1'b1)
      $display("interpolation test, period select %0d, done", sel);
   endtask

   task automatic t_fill();
      int                 n;
      int                 i;
      logic signed [15:0] held;
      do_reset('{final_slow: 1'b0, narrow_out: 1'b0, chain_period_sel: 2'h0});
      stall <= 1'b1;
      n = 0;
      @(posedge clk);
      in_sample <= '{valid: 1'b1, data: 16'sh0100};
      for (i = 0; i < 100; i++) begin
         @(posedge clk);
         if (in_ready !== 1'b1) break;
         n++;
         in_sample.data <= 16'(16'sh0100 + n);
      end
      if (i == 100) bail();
      in_sample.valid <= 1'b0;
      `CHK(n >= DEPTH_OK_LO && n <= FIFO_DEPTH_WORDS + 4, 1'b1)
      for (i = 0; i < 2000 && out_sample.valid !== 1'b1; i++) @(posedge clk);
      if (i == 2000) bail();
      held = out_sample.data;
      repeat (300) @(posedge clk);
      `CHK(out_sample.valid, 1'b1)
      `CHK(out_sample.data, held)
      `CHK(u_fmt.pts.size(), 0)
      stall <= 1'b0;
      wait_points(16 * n, 16 * n * 100 + 500);
      repeat (200) @(posedge clk);
      `CHK(u_fmt.pts.size(), 16 * n)
      `CHK(in_ready, 1'b1)
      $display("buffer fill and drain test done, %0d samples", n);
   endtask

   task automatic t_phases();
      int                 i;
      int                 c;
      int                 last;
      int                 chg;
      logic signed [15:0] prev;
      do_reset('{final_slow: 1'b0, narrow_out: 1'b0, chain_period_sel: 2'h0});
      in_sample <= '{valid: 1'b1, data: 16'sh4000};
      `CHK(phase, PH0)
      for (i = 0; i < 6; i++) begin
         for (c = 0; c < 40000 && phase === phase_t'(7'h01 << i); c++) @(posedge clk);
         if (c == 40000) bail();
         `CHK(c + 1 >= (TICKS[i] - 2) * UPD && c + 1 <= (TICKS[i] + 2) * UPD, 1'b1)
         `CHK(phase, phase_t'(7'h01 << (i + 1)))
      end
      // input falls to zero: the limited offset must walk down in fixed steps
      in_sample.data <= 16'sh0000;
      prev = applied_offset;
      last = 0;
      chg = 0;
      for (c = 1; c <= 6000; c++) begin
         @(posedge clk);
         if (c == 3000) cfg.narrow_out <= 1'b1;
         if (applied_offset !== prev) begin
            if (c > 3002) `CHK(16'(prev - applied_offset), 16'(STEP_NARROW))
            else `CHK(16'(prev - applied_offset), 16'(LIMIT_STEP_WIDE_LSB))
            `CHK(chg == 0 || c - last >= LIM, 1'b1)
            last = c;
            chg++;
            prev = applied_offset;
         end
      end
      `CHK(chg > 0, 1'b1)
      `CHK(phase, PH_FINAL)
      in_sample.valid <= 1'b0;
      $display("phase sequence and limiter test done, %0d steps", chg);
   endtask

   // final phase switched to the slow variant: estimate moves on slow ticks only
   task automatic t_final_slow();
      int                 c;
      int                 last;
      int                 chg;
      logic signed [15:0] prev;
      cfg.final_slow <= 1'b1;
      repeat (2) @(posedge clk);
      prev = applied_offset;
      last = 0;
      chg = 0;
      for (c = 1; c <= 2000; c++) begin
         @(posedge clk);
         if (applied_offset !== prev) begin
            if (chg > 0) `CHK((c - last) % SLOW, 0)
            last = c;
            chg++;
            prev = applied_offset;
         end
      end
      `CHK(chg > 1, 1'b1)
      `CHK(phase, PH_FINAL)
      $display("slow final variant test done, %0d changes", chg);
   endtask

   initial begin
      rst_n = 1'b0;
      cfg = '0;
      in_sample = '0;
      stall = 1'b0;
      for (s = 0; s < 4; s++) t_interp(2'(s));
      t_fill();
      t_phases();
      t_final_slow();
      summarize();
   end
endmodule
